// ---- core/cpu_core_params.svh ----
`ifndef CPU_CORE_PARAMS_SVH
`define CPU_CORE_PARAMS_SVH
// register byte offsets
`define CPU_OFF_CMD      8'h00
`define CPU_OFF_STATE    8'h04
`define CPU_OFF_PC       8'h08
`define CPU_OFF_RAM_PTR  8'h0C
`define CPU_OFF_EREG     8'h10
`define CPU_OFF_ROM_ADDR 8'h14
`define CPU_OFF_ROM_DATA 8'h18
`define CPU_OFF_RAM_DATA 8'h1C
`define CPU_OFF_PORT     8'h20
// field ranges
`define CPU_F_OP    4:0
`define CPU_F_ARG   26:16
`define CPU_F_BUSY  0
`define CPU_F_A     3:0
`define CPU_F_B     7:4
`define CPU_F_CARRY 8
`define CPU_F_D     12:10
`define CPU_F_Y     3:0
`define CPU_F_X     5:4
`define CPU_F_E     7:0
`define CPU_F_ROM   8:0
`define CPU_F_NIB   3:0
`define CPU_F_PORT  7:0
// timing and structure
`define CPU_ICLK_DIV      4
`define CPU_INPAGE_BITS   7
`define CPU_PAGE_WORDS    128
`define CPU_CALL_PAGE     2
`define CPU_STACK_DEPTH   4
`define CPU_LEVEL_RESET   2'h3
`define CPU_TABLE_EXTRA   2'h2
`define CPU_RETURN_EXTRA  2'h1
`define CPU_ROM_TOP_BIT   8
`define CPU_PORT_BITS     8
`endif

// ---- core/cpu_core_pkg.sv ----
package cpu_core_pkg;
  typedef enum logic [4:0] {
    nop_op                = 5'h00,
    add_imm_op            = 5'h01,
    add_memory_op         = 5'h02,
    add_mem_carry_op      = 5'h03,
    rotate_right_op       = 5'h04,
    set_carry_op          = 5'h05,
    reset_carry_op        = 5'h06,
    cmp_skip_op           = 5'h07,
    mem_bit_set_op        = 5'h08,
    mem_bit_clear_op      = 5'h09,
    mem_bit_test_skip_op  = 5'h0A,
    port_bit_set_op       = 5'h0B,
    port_bit_clear_op     = 5'h0C,
    port_bit_test_skip_op = 5'h0D,
    load_a_op             = 5'h0E,
    xch_ab_op             = 5'h0F,
    xch_acc_mem_op        = 5'h10,
    e_from_pair_op        = 5'h11,
    pair_from_e_op        = 5'h12,
    load_d_op             = 5'h13,
    rom_top_bit_enable_op = 5'h14,
    rom_table_read_op     = 5'h15,
    page_jump_reg_op      = 5'h16,
    page2_call_reg_op     = 5'h17,
    page2_call_op         = 5'h18,
    return_op             = 5'h19,
    jump_op               = 5'h1A,
    call_op               = 5'h1B
  } op_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_wait = 3'b010,
    st_busy = 3'b100
  } exec_state_t;
endpackage

// ---- core/stack_if.sv ----
`timescale 1ns/100ps
interface stack_if #(parameter int AW = 11);
  logic          push;
  logic          pop;
  logic [AW-1:0] push_pc;
  logic [AW-1:0] top_pc;
  logic [1:0]    level;
  modport core  (output push, output pop, output push_pc, input top_pc, input level);
  modport stack (input push, input pop, input push_pc, output top_pc, output level);
endinterface

// ---- core/cpu_return_stack.sv ----
`timescale 1ns/100ps
`include "cpu_core_params.svh"
module cpu_return_stack #(
  parameter int DEPTH = 4,
  parameter int AW    = 11
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // stack access
  stack_if.stack    stk
);
  logic [AW-1:0] entry_q [DEPTH];
  logic [1:0]    level_q;

  if (DEPTH != `CPU_STACK_DEPTH) begin : g_bad_depth
    $error("return stack depth must be four");
  end

  assign stk.top_pc = entry_q[level_q];
  assign stk.level  = level_q;

  // [RULE13] pointer wraps silently
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      level_q <= `CPU_LEVEL_RESET;
    end else if (stk.push) begin
      level_q <= level_q + 2'h1;
    end else if (stk.pop) begin
      level_q <= level_q - 2'h1;
    end
  end

  // [RULE13] fifth push overwrites oldest
  always_ff @(posedge i_clk) begin
    if (stk.push) begin
      entry_q[level_q + 2'h1] <= stk.push_pc;
    end
  end

  property p_push_level;
    @(posedge i_clk) disable iff (i_reset)
    stk.push |=> level_q == $past(level_q) + 2'h1;
  endproperty
  a_push_level: assert property (p_push_level) else $error("push did not advance level"); // [RULE13]

  property p_push_stores_pc;
    @(posedge i_clk) disable iff (i_reset)
    stk.push |=> stk.top_pc == $past(stk.push_pc);
  endproperty
  a_push_stores_pc: assert property (p_push_stores_pc) else $error("pushed pc not on top"); // [RULE12]
endmodule // cpu_return_stack

// ---- core/cpu_program_state_core.sv ----
// What this block does
// [RULE1] alu adds, compares and manipulates single bits on 4-bit operands
// [RULE2] 4-bit accumulator is operand and result for alu, transfers, ports; port bit ops here use digit y, not the accumulator
// [RULE3] add memory with carry sets carry flag from 4-bit sum carry out
// [RULE4] add immediate and add memory never touch the carry flag
// [RULE5] rotate right moves accumulator bit 0 into carry
// [RULE6] set carry and reset carry force the flag to one or zero
// [RULE7] second 4-bit register stores data and pairs with accumulator
// [RULE8] 8-bit register swaps with pair, high nibble second, low accumulator; the code only copies, one op each way
// [RULE9] 3-bit register plus accumulator give 7-bit in-page rom address
// [RULE10] table read copies rom bit 8 into carry only when top-bit flag set
// [RULE11] top-bit flag clears at reset and back-up return, set only
// [RULE12] call and table read push the pc, return restores it
// [RULE13] four stack entries, 2-bit pointer, deeper nesting overwrites
// [RULE14] skip only cancels next op; skipped table read or return: one cycle
// [RULE15] pc steps by one word, loads target on jumps, calls, returns, reads
// [RULE16] pc is page plus 7-bit in-page field; 127 rolls to next page
// [RULE17] data pointer is file plus digit; digit also picks port bit
// [RULE18] rom words are 9 bits in 128-word pages, 16 or 8 pages
// [RULE19] page 2 reachable from any page by one-word call
// [RULE20] any rom address readable as data by table read
// [RULE21] ram words 4 bits via data pointer, bit set, clear, test anywhere
// [RULE22] ram holds 64 words or 48 words depending on variant
// [RULE23] instruction clock is system clock over four, one machine cycle
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "cpu_core_params.svh"
module cpu_program_state_core
  import cpu_core_pkg::*;
#(
  parameter int ROM_PAGES = 16,
  parameter int RAM_WORDS = 64
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // port and back-up return
  input  wire logic [7:0]  i_port_d,
  input  wire logic        i_backup_wake,
  output logic      [7:0]  o_port_d
);
  localparam int PW = $clog2(ROM_PAGES);
  localparam int AW = PW + `CPU_INPAGE_BITS;
  localparam int ROM_WORDS = ROM_PAGES * `CPU_PAGE_WORDS;
  localparam int DW = $clog2(`CPU_ICLK_DIV);

  // [RULE18] [RULE22] variant check
  if (!((ROM_PAGES == 8 || ROM_PAGES == 16) && (RAM_WORDS == 48 || RAM_WORDS == 64))) begin : g_bad
    $error("unsupported rom or ram size");
  end

  logic [3:0]    a_q, b_q, y_q;
  logic [2:0]    d_q;
  logic [1:0]    x_q, cyc_q;
  logic [7:0]    e_q, port_q, port_s1_q, port_s2_q;
  logic          carry_q, rom_top_bit_flag_q, skip_q, tick_q, tbl_q;
  logic [DW-1:0] div_q;
  logic [AW-1:0] pc_q, rom_addr_q;
  logic [8:0]    rom [ROM_WORDS];
  logic [3:0]    ram [RAM_WORDS];
  logic [2:0]    wake_q;
  exec_state_t   state_q;
  op_t           op_q;
  logic [10:0]   arg_q;
  logic          pready_q, pslverr_q;
  logic [31:0]   prdata_q, rd_mux;

  stack_if #(.AW(AW)) stk_bus ();

  cpu_return_stack #(
    .DEPTH (`CPU_STACK_DEPTH),
    .AW    (AW)
  ) u_stack (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .stk     (stk_bus.stack)
  );

  // decode and datapath
  logic          access_new, wr_go, idle, exec, run, tbl_done;
  logic [5:0]    ram_idx;
  logic          ram_ok;
  logic [3:0]    mem;
  logic [4:0]    sum_imm, sum_mem, sum_amc;
  logic [AW-1:0] pc_inc, reg_target, tbl_addr;
  logic [8:0]    rom_word;
  logic [1:0]    bit_j;

  assign access_new = i_psel && i_penable && !pready_q;
  assign wr_go      = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
  assign idle       = state_q == st_idle;
  // [RULE23] one tick per machine cycle
  assign exec       = state_q == st_wait && tick_q;
  // [RULE14] skip cancels only the op
  assign run        = exec && !skip_q;
  assign tbl_done   = state_q == st_busy && tick_q && cyc_q == `CPU_RETURN_EXTRA && tbl_q;
  // [RULE17] [RULE21] file and digit address
  assign ram_idx    = {x_q, y_q};
  assign ram_ok     = int'(ram_idx) < RAM_WORDS;
  assign mem        = ram_ok ? ram[ram_idx] : 4'h0;
  assign bit_j      = arg_q[1:0];
  // [RULE1] 4-bit sums
  assign sum_imm    = {1'b0, a_q} + {1'b0, arg_q[`CPU_F_NIB]};
  assign sum_mem    = {1'b0, a_q} + {1'b0, mem};
  assign sum_amc    = sum_mem + {4'h0, carry_q};
  // [RULE16] page carry falls out of the add
  assign pc_inc     = pc_q + AW'(1);
  // [RULE9] page, d and accumulator
  assign reg_target = {arg_q[PW-1:0], d_q, a_q};
  assign tbl_addr   = reg_target;
  // [RULE20] whole rom readable as data
  assign rom_word   = rom[tbl_addr];

  // [RULE12] push on calls and table read
  assign stk_bus.push    = run && (op_q == call_op || op_q == page2_call_op || op_q == page2_call_reg_op
                                   || op_q == rom_table_read_op);
  assign stk_bus.pop     = (run && op_q == return_op) || tbl_done;
  assign stk_bus.push_pc = pc_inc;

  // [RULE23] instruction clock divider
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_q + DW'(1);
      tick_q <= div_q == DW'(`CPU_ICLK_DIV - 1);
    end
  end

  // port pins and wake pin are asynchronous
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      port_s1_q <= 8'h00;
      port_s2_q <= 8'h00;
      wake_q    <= 3'h0;
    end else begin
      port_s1_q <= i_port_d;
      port_s2_q <= port_s1_q;
      wake_q    <= {wake_q[1:0], i_backup_wake};
    end
  end

  // command sequencer
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= st_idle;
      op_q    <= nop_op;
      arg_q   <= 11'h000;
      cyc_q   <= 2'h0;
      tbl_q   <= 1'b0;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (wr_go && i_paddr == `CPU_OFF_CMD) begin
            op_q    <= op_t'(i_pwdata[`CPU_F_OP]);
            arg_q   <= i_pwdata[`CPU_F_ARG];
            state_q <= st_wait;
          end
        end
        st_wait: begin
          if (tick_q) begin
            // [RULE14] skipped slow ops finish in one cycle
            if (run && op_q == rom_table_read_op) begin
              cyc_q   <= `CPU_TABLE_EXTRA;
              tbl_q   <= 1'b1;
              state_q <= st_busy;
            end else if (run && op_q == return_op) begin
              cyc_q   <= `CPU_RETURN_EXTRA;
              state_q <= st_busy;
            end else begin
              state_q <= st_idle;
            end
          end
        end
        st_busy: begin
          if (tick_q) begin
            cyc_q <= cyc_q - 2'h1;
            if (cyc_q == `CPU_RETURN_EXTRA) begin
              state_q <= st_idle;
              tbl_q   <= 1'b0;
            end
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // accumulator, b, carry, d, e
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      a_q     <= 4'h0;
      b_q     <= 4'h0;
      carry_q <= 1'b0;
      d_q     <= 3'h0;
      e_q     <= 8'h00;
    end else if (wr_go && i_paddr == `CPU_OFF_STATE) begin
      a_q     <= i_pwdata[`CPU_F_A];
      b_q     <= i_pwdata[`CPU_F_B];
      carry_q <= i_pwdata[`CPU_F_CARRY];
      d_q     <= i_pwdata[`CPU_F_D];
    end else if (wr_go && i_paddr == `CPU_OFF_EREG) begin
      e_q <= i_pwdata[`CPU_F_E];
    end else if (run) begin
      unique case (op_q)
        // [RULE4] carry left alone
        add_imm_op:    a_q <= sum_imm[3:0];
        add_memory_op: a_q <= sum_mem[3:0];
        // [RULE3] carry out of sum
        add_mem_carry_op: begin
          a_q     <= sum_amc[3:0];
          carry_q <= sum_amc[4];
        end
        // [RULE5] bit 0 into carry
        rotate_right_op: begin
          a_q     <= {carry_q, a_q[3:1]};
          carry_q <= a_q[0];
        end
        // [RULE6] forced carry values
        set_carry_op:   carry_q <= 1'b1;
        reset_carry_op: carry_q <= 1'b0;
        // [RULE2] [RULE7] transfers and exchanges
        load_a_op: a_q <= arg_q[`CPU_F_NIB];
        xch_ab_op: begin
          a_q <= b_q;
          b_q <= a_q;
        end
        xch_acc_mem_op: a_q <= mem;
        // [RULE8] b high, a low
        e_from_pair_op: e_q <= {b_q, a_q};
        pair_from_e_op: begin
          b_q <= e_q[7:4];
          a_q <= e_q[3:0];
        end
        load_d_op: d_q <= arg_q[2:0];
        // [RULE10] top bit only when enabled
        rom_table_read_op: begin
          b_q <= rom_word[7:4];
          a_q <= rom_word[3:0];
          if (rom_top_bit_flag_q) begin
            carry_q <= rom_word[`CPU_ROM_TOP_BIT];
          end
        end
        default: a_q <= a_q;
      endcase
    end
  end

  // [RULE11] set only; a same-cycle set beats wake
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rom_top_bit_flag_q <= 1'b0;
    end else if (run && op_q == rom_top_bit_enable_op) begin
      rom_top_bit_flag_q <= 1'b1;
    end else if (wake_q[1] && !wake_q[2]) begin
      rom_top_bit_flag_q <= 1'b0;
    end
  end

  // [RULE1] [RULE14] compare and bit tests
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      skip_q <= 1'b0;
    end else if (exec) begin
      unique case (op_q)
        cmp_skip_op:           skip_q <= !skip_q && a_q == mem;
        mem_bit_test_skip_op:  skip_q <= !skip_q && !mem[bit_j];
        port_bit_test_skip_op: skip_q <= !skip_q && y_q < `CPU_PORT_BITS && !port_s2_q[y_q[2:0]];
        default:               skip_q <= 1'b0;
      endcase
    end
  end

  // [RULE15] program counter
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pc_q <= '0;
    end else if (wr_go && i_paddr == `CPU_OFF_PC) begin
      pc_q <= i_pwdata[AW-1:0];
    end else if (tbl_done) begin
      pc_q <= stk_bus.top_pc;
    end else if (exec && skip_q) begin
      pc_q <= pc_inc;
    end else if (run) begin
      unique case (op_q)
        jump_op, call_op:                    pc_q <= arg_q[AW-1:0];
        page_jump_reg_op, page2_call_reg_op: pc_q <= reg_target;
        // [RULE19] one-word call into page 2
        page2_call_op:     pc_q <= {PW'(`CPU_CALL_PAGE), arg_q[6:0]};
        rom_table_read_op: pc_q <= tbl_addr;
        return_op:         pc_q <= stk_bus.top_pc;
        default:           pc_q <= pc_inc;
      endcase
    end
  end

  // [RULE17] data pointer
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      x_q <= 2'h0;
      y_q <= 4'h0;
    end else if (wr_go && i_paddr == `CPU_OFF_RAM_PTR) begin
      x_q <= i_pwdata[`CPU_F_X];
      y_q <= i_pwdata[`CPU_F_Y];
    end
  end

  // [RULE17] digit picks port bit
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      port_q <= 8'h00;
    end else if (wr_go && i_paddr == `CPU_OFF_PORT) begin
      port_q <= i_pwdata[`CPU_F_PORT];
    end else if (run && y_q < `CPU_PORT_BITS) begin
      if (op_q == port_bit_set_op) begin
        port_q[y_q[2:0]] <= 1'b1;
      end else if (op_q == port_bit_clear_op) begin
        port_q[y_q[2:0]] <= 1'b0;
      end
    end
  end

  // [RULE21] ram nibbles and bit ops
  always_ff @(posedge i_clk) begin
    if (ram_ok) begin
      if (wr_go && i_paddr == `CPU_OFF_RAM_DATA) begin
        ram[ram_idx] <= i_pwdata[`CPU_F_NIB];
      end else if (run && op_q == xch_acc_mem_op) begin
        ram[ram_idx] <= a_q;
      end else if (run && op_q == mem_bit_set_op) begin
        ram[ram_idx][bit_j] <= 1'b1;
      end else if (run && op_q == mem_bit_clear_op) begin
        ram[ram_idx][bit_j] <= 1'b0;
      end
    end
  end

  // [RULE18] rom loader, address steps after each word
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rom_addr_q <= '0;
    end else if (wr_go && i_paddr == `CPU_OFF_ROM_ADDR) begin
      rom_addr_q <= i_pwdata[AW-1:0];
    end else if (wr_go && i_paddr == `CPU_OFF_ROM_DATA) begin
      rom_addr_q <= rom_addr_q + AW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr_go && i_paddr == `CPU_OFF_ROM_DATA) begin
      rom[rom_addr_q] <= i_pwdata[`CPU_F_ROM];
    end
  end

  // register read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_paddr)
      `CPU_OFF_CMD:      rd_mux[`CPU_F_BUSY] = !idle;
      `CPU_OFF_STATE:    rd_mux = {16'h0000, stk_bus.level, skip_q, d_q, rom_top_bit_flag_q, carry_q, b_q, a_q};
      `CPU_OFF_PC:       rd_mux[AW-1:0] = pc_q;
      `CPU_OFF_RAM_PTR:  rd_mux[5:0] = {x_q, y_q};
      `CPU_OFF_EREG:     rd_mux[7:0] = e_q;
      `CPU_OFF_ROM_ADDR: rd_mux[AW-1:0] = rom_addr_q;
      `CPU_OFF_ROM_DATA: rd_mux[8:0] = rom[rom_addr_q];
      `CPU_OFF_RAM_DATA: rd_mux[3:0] = mem;
      `CPU_OFF_PORT:     rd_mux[7:0] = port_q;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state; writes refused while an op runs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= access_new;
      if (access_new) begin
        prdata_q  <= i_pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_q <= i_paddr > `CPU_OFF_PORT || i_paddr[1:0] != 2'h0 || (i_pwrite && !idle);
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_port_d  = port_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_amc_carry;
    run && op_q == add_mem_carry_op |=> carry_q == $past(sum_amc[4]) && a_q == $past(sum_amc[3:0]);
  endproperty
  a_amc_carry: assert property (p_amc_carry) else $error("carry wrong after add with carry"); // [RULE3]

  property p_add_keeps_carry;
    run && (op_q == add_imm_op || op_q == add_memory_op) |=> $stable(carry_q);
  endproperty
  a_add_keeps_carry: assert property (p_add_keeps_carry) else $error("plain add changed carry"); // [RULE4]

  property p_rotate;
    run && op_q == rotate_right_op |=> carry_q == $past(a_q[0]) && a_q[3] == $past(carry_q);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate right wrong"); // [RULE5]

  property p_force_carry;
    run && (op_q == set_carry_op || op_q == reset_carry_op) |=> carry_q == $past(op_q == set_carry_op);
  endproperty
  a_force_carry: assert property (p_force_carry) else $error("carry not forced"); // [RULE6]

  property p_table_top_bit;
    run && op_q == rom_table_read_op |=>
      carry_q == ($past(rom_top_bit_flag_q) ? $past(rom_word[8]) : $past(carry_q));
  endproperty
  a_table_top_bit: assert property (p_table_top_bit) else $error("table read top bit wrong"); // [RULE10]

  property p_top_bit_sticky;
    !$past(i_reset) && !$past(wake_q[1] && !wake_q[2]) |-> !$fell(rom_top_bit_flag_q);
  endproperty
  a_top_bit_sticky: assert property (p_top_bit_sticky) else $error("top-bit flag cleared by software"); // [RULE11]

  property p_tick_period;
    tick_q |=> !tick_q [*3] ##1 tick_q;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("instruction clock not divide by four"); // [RULE23]

  property p_skip_one_cycle;
    exec && skip_q |=> idle && !skip_q && pc_q == $past(pc_inc) && $stable(a_q);
  endproperty
  a_skip_one_cycle: assert property (p_skip_one_cycle) else $error("skipped op not cancelled"); // [RULE14]

  property p_page_roll;
    run && op_q == nop_op && pc_q[6:0] == 7'h7F |=> pc_q[6:0] == 7'h00 && pc_q[AW-1:7] == $past(pc_q[AW-1:7]) + 1'b1;
  endproperty
  a_page_roll: assert property (p_page_roll) else $error("pc did not roll into next page"); // [RULE16]

  c_amc_carry_out: cover property (run && op_q == add_mem_carry_op && sum_amc[4]);
  c_table_read:    cover property (tbl_done);
  c_skip_taken:    cover property (exec && skip_q);
  c_page_roll:     cover property (run && pc_q[6:0] == 7'h7F);
endmodule // cpu_program_state_core

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`include "cpu_core_params.svh"
module testbench
  import cpu_core_pkg::*;
;
  logic        clk, rst, psel, pen, pwr, wake, pready, pslverr, rerr;
  logic [7:0]  paddr, port_in, port_out, seed;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  a, m;
  logic [8:0]  rw;
  int          failures, check_count;
  localparam logic [7:0] ST = `CPU_OFF_STATE;
  localparam logic [7:0] PCR = `CPU_OFF_PC;
  localparam logic [7:0] DPR = `CPU_OFF_RAM_PTR;

  cpu_program_state_core cpu_program_state_core_inst (
    .i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_port_d(port_in), .i_backup_wake(wake), .o_port_d(port_out)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // carry in bit 8, sum in the low nibble
  function automatic logic [8:0] amc_exp(input logic [3:0] x, input logic [3:0] y);
    logic [4:0] s;
    s = {1'b0, x} + {1'b0, y};
    return {s[4], 4'h0, s[3:0]};
  endfunction

  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // busy polled, never a fixed wait
  task automatic cmd(input op_t op, input logic [10:0] arg);
    apb(1'b1, `CPU_OFF_CMD, {5'h00, arg, 11'h000, op});
    do apb(1'b0, `CPU_OFF_CMD, 32'h0); while (rdat[0] !== 1'b0);
  endtask

  task automatic setst(input logic [3:0] x, input logic [3:0] b, input logic c, input logic [2:0] d);
    apb(1'b1, ST, {19'h0, d, 1'b0, c, b, x});
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // run needs well under this span
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    wake = 1'b0; port_in = 8'h00; seed = 8'h4C; failures = 0; check_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'hFFFF, 32'hC000);
    apb(1'b0, 8'h24, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    apb(1'b1, DPR, 32'h12);
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 4'hF : seed[3:0];
      m = (i == 0) ? 4'h1 : seed[7:4];
      port_in <= seed;
      apb(1'b1, DPR, 32'h10 + i);
      apb(1'b1, `CPU_OFF_RAM_DATA, {28'h0, m});
      setst(a, 4'h0, 1'b1, 3'h0);
      cmd(add_memory_op, 11'h0);
      apb(1'b0, ST, 32'h0);
      chk(rdat & 32'h1FF, {23'h0, 1'b1, 4'h0, a + m});
      setst(a, 4'h0, 1'b0, 3'h0);
      cmd(add_mem_carry_op, 11'h0);
      apb(1'b0, ST, 32'h0);
      chk(rdat & 32'h1FF, {23'h0, amc_exp(a, m)});
      // low pin at digit y skips; a nop eats the skip
      cmd(port_bit_test_skip_op, 11'h0);
      apb(1'b0, ST, 32'h0);
      chk(rdat & 32'h2000, {18'h0, ~seed[i], 13'h0});
      cmd(nop_op, 11'h0);
    end
    setst(4'h5, 4'h0, 1'b0, 3'h0);
    cmd(rotate_right_op, 11'h0);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h100, 32'h100);
    cmd(reset_carry_op, 11'h0);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h100, 32'h0);
    cmd(set_carry_op, 11'h0);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h100, 32'h100);
    setst(4'hA, 4'h3, 1'b0, 3'h0);
    cmd(e_from_pair_op, 11'h0);
    apb(1'b0, `CPU_OFF_EREG, 32'h0);
    chk(rdat, 32'h3A);
    setst(4'h0, 4'h0, 1'b0, 3'h0);
    apb(1'b1, `CPU_OFF_EREG, 32'hC5);
    cmd(pair_from_e_op, 11'h0);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'hFF, 32'hC5);
    seed = lfsr(seed);
    rw = {1'b1, seed};
    apb(1'b1, `CPU_OFF_ROM_ADDR, {21'h0, 4'h6, 3'h5, 4'h9});
    apb(1'b1, `CPU_OFF_ROM_DATA, {23'h0, rw});
    apb(1'b1, PCR, 32'h40);
    setst(4'h9, 4'h0, 1'b0, 3'h5);
    // a state write while the read runs must be refused
    apb(1'b1, `CPU_OFF_CMD, {5'h00, 11'h006, 11'h000, rom_table_read_op});
    setst(4'hF, 4'hF, 1'b1, 3'h0);
    chk({31'h0, rerr}, 32'h1);
    do apb(1'b0, `CPU_OFF_CMD, 32'h0); while (rdat[0] !== 1'b0);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h3FF, {24'h0, rw[7:0]});
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h41);
    cmd(rom_top_bit_enable_op, 11'h0);
    setst(4'h9, 4'h0, 1'b0, 3'h5);
    cmd(rom_table_read_op, 11'h006);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h3FF, {22'h0, 1'b1, rw});
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h200, 32'h0);
    apb(1'b1, PCR, 32'h5A0);
    cmd(page2_call_op, 11'h010);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h110);
    cmd(return_op, 11'h0);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h5A1);
    apb(1'b1, PCR, 32'h17F);
    cmd(nop_op, 11'h0);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h180);
    apb(1'b1, `CPU_OFF_RAM_DATA, 32'h0);
    cmd(reset_carry_op, 11'h0);
    apb(1'b1, PCR, 32'h200);
    cmd(mem_bit_test_skip_op, 11'h001);
    cmd(set_carry_op, 11'h0);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h100, 32'h0);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h202);
    cmd(mem_bit_set_op, 11'h002);
    apb(1'b0, `CPU_OFF_RAM_DATA, 32'h0);
    chk(rdat, 32'h4);
    apb(1'b1, DPR, 32'h05);
    cmd(port_bit_set_op, 11'h0);
    chk({24'h0, port_out}, 32'h20);
    cmd(port_bit_clear_op, 11'h0);
    chk({24'h0, port_out}, 32'h0);
    // equal compare cancels the next add
    setst(4'h9, 4'h0, 1'b1, 3'h0);
    apb(1'b1, `CPU_OFF_RAM_DATA, 32'h9);
    cmd(cmp_skip_op, 11'h0);
    cmd(add_imm_op, 11'h001);
    cmd(add_imm_op, 11'h00A);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h10F, 32'h103);
    cmd(load_a_op, 11'h006);
    cmd(xch_ab_op, 11'h0);
    cmd(xch_acc_mem_op, 11'h0);
    cmd(load_d_op, 11'h005);
    apb(1'b0, ST, 32'h0);
    chk(rdat & 32'h1CFF, 32'h1469);
    apb(1'b1, `CPU_OFF_RAM_DATA, 32'hF);
    cmd(mem_bit_clear_op, 11'h003);
    apb(1'b0, `CPU_OFF_RAM_DATA, 32'h0);
    chk(rdat, 32'h7);
    cmd(jump_op, 11'h3C5);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h3C5);
    cmd(page2_call_reg_op, 11'h003);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h1D9);
    cmd(return_op, 11'h0);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h3C6);
    cmd(page_jump_reg_op, 11'h00A);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h559);
    // fifth call overwrites the oldest entry
    apb(1'b1, PCR, 32'h0);
    for (int k = 1; k < 6; k++) cmd(call_op, 11'(k << 8));
    repeat (5) cmd(return_op, 11'h0);
    apb(1'b0, PCR, 32'h0);
    chk(rdat, 32'h401);
    give_verdict();
  end
endmodule // testbench
